//--- core/msps_top.sv
// APB-mapped master/slave PWM sequencer with interrupt and pin control
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/100ps
// Overview of operation
// - Master and slave start bits written together; they read back as zero.
// - Start sets both enable flags; master interrupts at once and starts slave.
// - Both count values are readable at any time.
// - Master loads period, counts down, reloads and interrupts at zero.
// - Each master interrupt loads the duty value into the slave counter while the slave is enabled or starting.
// - Output active one count clock after master interrupt, inactive at slave zero.
// - Stop bits written together clear both enable flags and halt counting.
// - Counters keep their values after a stop.
// - A stop leaves the output pin level unchanged.
// - With output enable clear, a written output level drives the pin.
// - Clearing the power enable resets everything and returns pin to port mode.
// - Output period equals the master period value plus one, in count clocks.
// - Duty of period plus one or more saturates to a fully active output.
module msps_top
    import msps_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire msps_pkg::msps_addr_t paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic irq,
    output logic pwm_output,
    output logic pwm_output_en
);
    import msps_pkg::*;

    // ==========================================================
    // State
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic irq_q;
    logic out_q;
    logic out_en_q;
    logic pwr_q;
    msps_cnt_t period_q;
    msps_cnt_t duty_q;
    msps_cnt_t mmode_q;
    msps_cnt_t smode_q;
    logic [OUTCFG_W-2:0] outcfg_q;
    logic [1:0] istat_q;
    logic [1:0] imask_q;
    logic [CKSEL_W-1:0] cksel_q;
    msps_cnt_t presc_q;
    msps_cnt_t pcnt;
    msps_cnt_t dcnt;
    logic m_en;
    logic s_en;
    logic m_irq;
    logic s_irq;
    logic act_set;
    logic act_clr;

    // ==========================================================
    // APB decode
    wire access = psel & penable & ~pready_q;
    wire wr = psel & penable & pwrite & pready_q;
    wire clr = ~pwr_q;
    wire sel_pwr = paddr == OFS_POWER;
    wire sel_trig = paddr == OFS_TRIG;
    wire sel_enstat = paddr == OFS_ENSTAT;
    wire sel_period = paddr == OFS_PERIOD;
    wire sel_duty = paddr == OFS_DUTY;
    wire sel_pcnt = paddr == OFS_PCNT;
    wire sel_dcnt = paddr == OFS_DCNT;
    wire sel_outcfg = paddr == OFS_OUTCFG;
    wire sel_mmode = paddr == OFS_MMODE;
    wire sel_smode = paddr == OFS_SMODE;
    wire sel_istat = paddr == OFS_ISTAT;
    wire sel_imask = paddr == OFS_IMASK;
    wire sel_cksel = paddr == OFS_CKSEL;
    wire mapped = sel_pwr | sel_trig | sel_enstat | sel_period | sel_duty | sel_pcnt
        | sel_dcnt | sel_outcfg | sel_mmode | sel_smode | sel_istat | sel_imask | sel_cksel;
    wire wr_on = wr & pwr_q;
    wire wr_trig = wr_on & sel_trig;
    wire wr_outcfg = wr_on & sel_outcfg;
    wire m_start = wr_trig & pwdata[BIT_MSTART];
    wire s_start = wr_trig & pwdata[BIT_SSTART];
    wire m_stop = wr_trig & pwdata[BIT_MSTOP];
    wire s_stop = wr_trig & pwdata[BIT_SSTOP];
    wire soe = outcfg_q[BIT_SOE];
    wire slvl = outcfg_q[BIT_SLVL];
    wire [OUTCFG_W-1:0] outcfg_rd = {out_q, outcfg_q};
    wire [1:0] ev = {s_irq, m_irq};

    // Counts read live, also while running
    wire [31:0] rdata =
        sel_pwr ? {31'h0, pwr_q} :
        sel_enstat ? {30'h0, s_en, m_en} :
        sel_period ? {16'h0, period_q} :
        sel_duty ? {16'h0, duty_q} :
        sel_pcnt ? {16'h0, pcnt} :
        sel_dcnt ? {16'h0, dcnt} :
        sel_outcfg ? {26'h0, outcfg_rd} :
        sel_mmode ? {16'h0, mmode_q} :
        sel_smode ? {16'h0, smode_q} :
        sel_istat ? {30'h0, istat_q} :
        sel_imask ? {30'h0, imask_q} :
        sel_cksel ? {28'h0, cksel_q} :
        32'h0000_0000;

    // ==========================================================
    // Count clock prescaler
    wire msps_cnt_t presc_mask = msps_cnt_t'((17'h00001 << cksel_q) - 17'h00001);
    wire tick = (presc_q & presc_mask) == RST_CNT;

    // ==========================================================
    // Channels
    msps_master u_master (
        .pclk(pclk),
        .presetn(presetn),
        .clr(clr),
        .tick(tick),
        .start(m_start),
        .stop(m_stop),
        .period_reload(period_q),
        .period_counter(pcnt),
        .master_enable_status(m_en),
        .period_interrupt(m_irq)
    );

    msps_slave u_slave (
        .pclk(pclk),
        .presetn(presetn),
        .clr(clr),
        .tick(tick),
        .start(s_start),
        .stop(s_stop),
        .master_irq(m_irq),
        .duty_reload(duty_q),
        .duty_counter(dcnt),
        .slave_enable_status(s_en),
        .duty_interrupt(s_irq),
        .act_set(act_set),
        .act_clr(act_clr)
    );

    // ==========================================================
    // Bus answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= access;
            prdata_q <= (access && !pwrite) ? rdata : 32'h0000_0000;
            pslverr_q <= access & ~mapped;
        end
    end

    // ==========================================================
    // Power enable, always writable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pwr_q <= 1'b0;
        else if (wr && sel_pwr)
            pwr_q <= pwdata[BIT_PWR];
    end

    // ==========================================================
    // Configuration registers, reset while powered off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            period_q <= RST_CNT;
            duty_q <= RST_CNT;
            mmode_q <= RST_CNT;
            smode_q <= RST_CNT;
            outcfg_q <= RST_OUTCFG[OUTCFG_W-2:0];
            imask_q <= RST_IRQ;
            cksel_q <= RST_CKSEL;
        end
        else if (clr)
        begin
            period_q <= RST_CNT;
            duty_q <= RST_CNT;
            mmode_q <= RST_CNT;
            smode_q <= RST_CNT;
            outcfg_q <= RST_OUTCFG[OUTCFG_W-2:0];
            imask_q <= RST_IRQ;
            cksel_q <= RST_CKSEL;
        end
        else if (wr_on)
        begin
            if (sel_period)
                period_q <= pwdata[CNT_W-1:0];
            if (sel_duty)
                duty_q <= pwdata[CNT_W-1:0];
            if (sel_mmode)
                mmode_q <= pwdata[CNT_W-1:0];
            if (sel_smode)
                smode_q <= pwdata[CNT_W-1:0];
            if (sel_outcfg)
                outcfg_q <= pwdata[OUTCFG_W-2:0];
            if (sel_imask)
                imask_q <= pwdata[1:0];
            if (sel_cksel)
                cksel_q <= pwdata[CKSEL_W-1:0];
        end
    end

    // ==========================================================
    // Prescaler, interrupt status and line
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presc_q <= RST_CNT;
            istat_q <= RST_IRQ;
            irq_q <= 1'b0;
        end
        else if (clr)
        begin
            presc_q <= RST_CNT;
            istat_q <= RST_IRQ;
            irq_q <= 1'b0;
        end
        else
        begin
            presc_q <= presc_q + 16'h0001;
            istat_q <= ev | (istat_q & ~((wr_on && sel_istat) ? pwdata[1:0] : 2'h0));
            irq_q <= |(istat_q & imask_q);
        end
    end

    // ==========================================================
    // Output bit and pin drive
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_q <= 1'b0;
            out_en_q <= 1'b0;
        end
        else if (clr)
        begin
            out_q <= 1'b0;
            out_en_q <= 1'b0;
        end
        else
        begin
            out_en_q <= outcfg_q[BIT_SOM];
            if (soe && act_set)
                out_q <= ~slvl;
            else if (soe && act_clr)
                out_q <= slvl;
            else if (wr_outcfg && !soe)
                out_q <= pwdata[BIT_OUTVAL];
        end
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign pwm_output = out_q;
    assign pwm_output_en = out_en_q;

    // ==========================================================
    // Checks
    property p_start;
        @(posedge pclk) disable iff (!presetn)
        (m_start && s_start && !m_stop && !s_stop) |=> m_en && s_en;
    endproperty
    a_start: assert property (p_start) else $error("start did not enable both channels");

    property p_start_irq;
        @(posedge pclk) disable iff (!presetn)
        (m_start && s_start && !m_stop && !s_stop) |=> dcnt == $past(duty_q);
    endproperty
    a_start_irq: assert property (p_start_irq) else $error("slave not started by start");

    property p_stop;
        @(posedge pclk) disable iff (!presetn)
        (m_stop && s_stop) |=> !m_en && !s_en;
    endproperty
    a_stop: assert property (p_stop) else $error("stop left a channel enabled");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (!m_en && !s_en && pwr_q && !m_start && !s_start) |=> $stable(pcnt) && $stable(dcnt);
    endproperty
    a_hold: assert property (p_hold) else $error("counts moved while stopped");

    property p_out_kept;
        @(posedge pclk) disable iff (!presetn)
        (!s_en && !s_start && pwr_q && !wr_outcfg && !(wr && sel_pwr)) |=> $stable(pwm_output);
    endproperty
    a_out_kept: assert property (p_out_kept) else $error("pin changed while stopped");

    property p_manual;
        @(posedge pclk) disable iff (!presetn)
        (wr_outcfg && !soe && !pwdata[BIT_SOE]) |=> pwm_output == $past(pwdata[BIT_OUTVAL]);
    endproperty
    a_manual: assert property (p_manual) else $error("written level not driven");

    property p_power_off;
        @(posedge pclk) disable iff (!presetn)
        !pwr_q |=> !pwm_output && !pwm_output_en && !m_en && !s_en;
    endproperty
    a_power_off: assert property (p_power_off) else $error("power off did not reset");

    property p_read_count;
        @(posedge pclk) disable iff (!presetn)
        (access && !pwrite && sel_pcnt) |=> prdata == {16'h0, $past(pcnt)};
    endproperty
    a_read_count: assert property (p_read_count) else $error("count read wrong");

    property p_zero_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_trig && pwdata[3:0] == 4'h0 && pwr_q) |=> m_en == $past(m_en) && s_en == $past(s_en);
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero trigger had effect");
endmodule : msps_top

//--- core/msps_pkg.sv
// Constants and types shared by the master/slave PWM sequencer
package msps_pkg;
    // ==========================================================
    // Widths and types
    localparam int CNT_W = 16;
    localparam int ADDR_W = 12;
    localparam int CKSEL_W = 4;
    typedef logic [CNT_W-1:0] msps_cnt_t;
    typedef logic [ADDR_W-1:0] msps_addr_t;
    // ==========================================================
    // Register offsets
    localparam msps_addr_t OFS_POWER = 12'h000;
    localparam msps_addr_t OFS_TRIG = 12'h004;
    localparam msps_addr_t OFS_ENSTAT = 12'h008;
    localparam msps_addr_t OFS_PERIOD = 12'h00C;
    localparam msps_addr_t OFS_DUTY = 12'h010;
    localparam msps_addr_t OFS_PCNT = 12'h014;
    localparam msps_addr_t OFS_DCNT = 12'h018;
    localparam msps_addr_t OFS_OUTCFG = 12'h01C;
    localparam msps_addr_t OFS_MMODE = 12'h020;
    localparam msps_addr_t OFS_SMODE = 12'h024;
    localparam msps_addr_t OFS_ISTAT = 12'h028;
    localparam msps_addr_t OFS_IMASK = 12'h02C;
    localparam msps_addr_t OFS_CKSEL = 12'h030;
    // ==========================================================
    // Field positions
    localparam int BIT_PWR = 0;
    localparam int BIT_MSTART = 0;
    localparam int BIT_SSTART = 1;
    localparam int BIT_MSTOP = 2;
    localparam int BIT_SSTOP = 3;
    localparam int BIT_MEN = 0;
    localparam int BIT_SEN = 1;
    localparam int BIT_SOE = 0;
    localparam int BIT_SLVL = 1;
    localparam int BIT_SOM = 2;
    localparam int BIT_MOM = 3;
    localparam int BIT_MLVL = 4;
    localparam int BIT_OUTVAL = 5;
    localparam int OUTCFG_W = 6;
    localparam int BIT_PIRQ = 0;
    localparam int BIT_DIRQ = 1;
    // ==========================================================
    // Reset values
    localparam msps_cnt_t RST_CNT = 16'h0000;
    localparam logic [OUTCFG_W-1:0] RST_OUTCFG = 6'h00;
    localparam logic [CKSEL_W-1:0] RST_CKSEL = 4'h0;
    localparam logic [1:0] RST_IRQ = 2'h0;
endpackage : msps_pkg

//--- core/msps_master.sv
// Master channel: period counter in repeating interval mode
`timescale 1ns/100ps
module msps_master
    import msps_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic tick,
    input wire logic start,
    input wire logic stop,
    input wire msps_pkg::msps_cnt_t period_reload,
    output msps_pkg::msps_cnt_t period_counter,
    output logic master_enable_status,
    output logic period_interrupt
);
    logic run_q;
    msps_cnt_t cnt_q;
    wire zero_hit = run_q & tick & (cnt_q == RST_CNT);

    // ==========================================================
    // Counter
    assign period_interrupt = (start & ~stop) | (zero_hit & ~stop);
    assign period_counter = cnt_q;
    assign master_enable_status = run_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_q <= 1'b0;
            cnt_q <= RST_CNT;
        end
        else if (clr)
        begin
            run_q <= 1'b0;
            cnt_q <= RST_CNT;
        end
        else if (stop)
        begin
            run_q <= 1'b0;
        end
        else if (start || zero_hit)
        begin
            run_q <= 1'b1;
            cnt_q <= period_reload;
        end
        else if (run_q && tick)
        begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end

    // ==========================================================
    // Checks
    property p_reload;
        @(posedge pclk) disable iff (!presetn)
        (zero_hit && !stop && !clr) |=> (cnt_q == $past(period_reload)) && run_q;
    endproperty
    a_reload: assert property (p_reload) else $error("period not reloaded at zero");

    property p_period;
        @(posedge pclk) disable iff (!presetn)
        (period_interrupt && !clr && period_reload == 16'h0004 && tick) ##1 (tick && !stop && !clr
            && !start)[*5] |-> period_interrupt;
    endproperty
    a_period: assert property (p_period) else $error("period interrupt spacing wrong");
endmodule : msps_master

//--- core/msps_slave.sv
// Slave channel: duty counter in one-count mode with output set/reset events
`timescale 1ns/100ps
module msps_slave
    import msps_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic tick,
    input wire logic start,
    input wire logic stop,
    input wire logic master_irq,
    input wire msps_pkg::msps_cnt_t duty_reload,
    output msps_pkg::msps_cnt_t duty_counter,
    output logic slave_enable_status,
    output logic duty_interrupt,
    output logic act_set,
    output logic act_clr
);
    logic run_q;
    logic cnt_en_q;
    logic arm_q;
    msps_cnt_t cnt_q;
    wire live = (run_q | start) & ~stop;
    wire trig = master_irq & live;
    wire zero_hit = run_q & ~stop & cnt_en_q & tick & (cnt_q == RST_CNT);

    // ==========================================================
    // Events
    assign duty_interrupt = zero_hit;
    assign act_clr = zero_hit;
    assign act_set = arm_q & tick & run_q & ~stop & ~zero_hit;
    assign duty_counter = cnt_q;
    assign slave_enable_status = run_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_q <= 1'b0;
            cnt_en_q <= 1'b0;
            arm_q <= 1'b0;
            cnt_q <= RST_CNT;
        end
        else if (clr)
        begin
            run_q <= 1'b0;
            cnt_en_q <= 1'b0;
            arm_q <= 1'b0;
            cnt_q <= RST_CNT;
        end
        else
        begin
            run_q <= live;
            if (trig)
            begin
                cnt_q <= duty_reload;
                cnt_en_q <= 1'b1;
                arm_q <= 1'b1;
            end
            else if (run_q && !stop && tick)
            begin
                arm_q <= 1'b0;
                if (zero_hit)
                    cnt_en_q <= 1'b0;
                else if (cnt_en_q)
                    cnt_q <= cnt_q - 16'h0001;
            end
        end
    end

    // ==========================================================
    // Checks
    property p_load;
        @(posedge pclk) disable iff (!presetn)
        (trig && !clr) |=> (cnt_q == $past(duty_reload)) && cnt_en_q;
    endproperty
    a_load: assert property (p_load) else $error("duty not loaded on master interrupt");

    sequence s_trig;
        trig && !clr;
    endsequence
    property p_set_next_tick;
        @(posedge pclk) disable iff (!presetn)
        s_trig ##1 (tick && run_q && !stop && !clr && !zero_hit) |-> act_set;
    endproperty
    a_set_next_tick: assert property (p_set_next_tick) else $error("output not set");

    property p_halt;
        @(posedge pclk) disable iff (!presetn)
        (zero_hit && !trig && !clr) |=> !cnt_en_q && $stable(cnt_q);
    endproperty
    a_halt: assert property (p_halt) else $error("slave kept counting after zero");
endmodule : msps_slave

//--- test/msps_pin_load.sv
// Far-side model: the load on the PWM pin with a port-register fallback
`timescale 1ns/100ps
module msps_pin_load
(
    input wire logic pclk,
    input wire logic pwm_output,
    input wire logic pwm_output_en,
    input wire logic port_level,
    input wire logic count_clr,
    output logic pin,
    output int high_count
);
    // ==========================================================
    // Pin level: timer while enabled, port register otherwise
    assign pin = pwm_output_en ? pwm_output : port_level;
    // ==========================================================
    // Active cycles seen by the load
    always_ff @(posedge pclk)
    begin
        if (count_clr)
            high_count <= 0;
        else if (pin)
            high_count <= high_count + 1;
    end
endmodule : msps_pin_load

//--- test/master_slave_pwm_sequencer_bench.sv
// Self-checking bench for the master/slave PWM sequencer
`timescale 1ns/100ps
module master_slave_pwm_sequencer_bench;
    import msps_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic pwm_output, pwm_output_en, port_level, count_clr, pin, err;
    msps_addr_t paddr;
    logic [31:0] pwdata, prdata, rd, ra;
    int mismatches, tests_run, high_count, n;
    // ==========================================================
    // Design and pin load
    msps_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq(irq), .pwm_output(pwm_output), .pwm_output_en(pwm_output_en));
    msps_pin_load load (.pclk(pclk), .pwm_output(pwm_output), .pwm_output_en(pwm_output_en),
        .port_level(port_level), .count_clr(count_clr), .pin(pin), .high_count(high_count));
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input msps_addr_t a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input msps_addr_t a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input msps_addr_t a, input logic [31:0] e, input string w);
        apb(1'b0, a, 32'h0);
        check(rd, e, w);
    endtask : rdc
    task automatic measure(output int cnt);
        @(posedge pclk);
        count_clr <= 1'b1;
        @(posedge pclk);
        count_clr <= 1'b0;
        repeat (20) @(posedge pclk);
        #1 cnt = high_count;
    endtask : measure
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    // ==========================================================
    // Scenarios
    task automatic t_power_off;
        wr(OFS_PERIOD, 32'h0000_0004);
        rdc(OFS_PERIOD, 32'h0, "period while off");
        rdc(12'h0FC, 32'h0, "unmapped read");
        check({31'h0, err}, 32'h1, "unmapped error");
        wr(OFS_POWER, 32'h1);
        wr(OFS_PERIOD, 32'h4);
        rdc(OFS_PERIOD, 32'h4, "period readback");
        $display("test power_off done");
    endtask : t_power_off
    task automatic t_pwm;
        wr(OFS_MMODE, 32'h1);
        wr(OFS_SMODE, 32'h2);
        wr(OFS_DUTY, 32'h2);
        wr(OFS_CKSEL, 32'h0);
        wr(OFS_OUTCFG, 32'h5);
        wr(OFS_TRIG, 32'h3);
        rdc(OFS_TRIG, 32'h0, "start bits self-clear");
        rdc(OFS_ENSTAT, 32'h3, "enables after start");
        apb(1'b0, OFS_ISTAT, 32'h0);
        check({31'h0, rd[BIT_PIRQ]}, 32'h1, "period interrupt");
        measure(n);
        check(n, 32'd8, "active cycles duty 2 period 5");
        apb(1'b0, OFS_PCNT, 32'h0);
        ra = rd;
        check({31'h0, ra[15:0] <= 16'h4}, 32'h1, "period count range");
        rdc(OFS_PCNT, {16'h0, ra[15:0] == 16'h4 ? 16'h0 : ra[15:0] + 16'h1}, "live count");
        $display("test pwm done");
    endtask : t_pwm
    task automatic t_saturate;
        wr(OFS_ISTAT, 32'h1);
        rd = 32'h0;
        while (rd[BIT_PIRQ] !== 1'b1)
            apb(1'b0, OFS_ISTAT, 32'h0);
        wr(OFS_DUTY, 32'h7);
        repeat (10) @(posedge pclk);
        measure(n);
        check(n, 32'd20, "duty above period saturates");
        wr(OFS_CKSEL, 32'h1);
        apb(1'b0, OFS_PCNT, 32'h0);
        ra = rd;
        ra[15:0] = ra[15:0] >= 16'h2 ? ra[15:0] - 16'h2 : ra[15:0] + 16'h3;
        rdc(OFS_PCNT, ra, "count at half rate");
        $display("test saturate done");
    endtask : t_saturate
    task automatic t_stop;
        wr(OFS_TRIG, 32'hC);
        rdc(OFS_ENSTAT, 32'h0, "enables after stop");
        rdc(OFS_TRIG, 32'h0, "stop bits self-clear");
        apb(1'b0, OFS_PCNT, 32'h0);
        ra = rd;
        repeat (10) @(posedge pclk);
        rdc(OFS_PCNT, ra, "count held");
        check({31'h0, pwm_output}, 32'h1, "pin held active");
        wr(OFS_TRIG, 32'h0);
        repeat (5) @(posedge pclk);
        rdc(OFS_ENSTAT, 32'h0, "zero write keeps stopped");
        rdc(OFS_PCNT, ra, "zero write keeps count");
        $display("test stop done");
    endtask : t_stop
    task automatic t_irq;
        wr(OFS_IMASK, 32'h0);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0, "masked irq");
        wr(OFS_IMASK, 32'h3);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h1, "unmasked irq");
        wr(OFS_ISTAT, 32'h3);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0, "cleared irq");
        rdc(OFS_ISTAT, 32'h0, "status cleared");
        $display("test irq done");
    endtask : t_irq
    task automatic t_level;
        wr(OFS_OUTCFG, 32'h04);
        wr(OFS_OUTCFG, 32'h04);
        wr(OFS_OUTCFG, 32'h24);
        repeat (2) @(posedge pclk);
        check({31'h0, pin}, 32'h1, "written level high");
        port_level <= 1'b1;
        wr(OFS_OUTCFG, 32'h04);
        repeat (2) @(posedge pclk);
        check({31'h0, pin}, 32'h0, "written level low");
        wr(OFS_POWER, 32'h0);
        repeat (2) @(posedge pclk);
        check({30'h0, pwm_output_en, pwm_output}, 32'h0, "pin released");
        check({31'h0, pin}, 32'h1, "port holds pin");
        rdc(OFS_OUTCFG, 32'h0, "cfg reset");
        rdc(OFS_DUTY, 32'h0, "duty reset");
        $display("test level done");
    endtask : t_level
    // ==========================================================
    // Clock, watchdog and main sequence
    initial
    begin
        pclk = 1'b0;
        forever
            #2.5 pclk = ~pclk;
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test;
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        port_level = 1'b0;
        count_clr = 1'b0;
        mismatches = 0;
        tests_run = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_power_off;
        t_pwm;
        t_saturate;
        t_stop;
        t_irq;
        t_level;
        stop_test;
    end
endmodule : master_slave_pwm_sequencer_bench
